//--- common/dbb_pkg.sv
// Package for the DSP boot vector and bridge configuration register bank
// Operation
// - 32-bit RW DSP boot vector, reset zero
// - Bits 31:30 select host data pad pull
// - Bit 29 set forces memory cke low
// - Bit 6 selects CPU-to-DSP bridge speed
// - Bits 11:10 convert CPU-to-DSP INCR reads
// - Bits 9:8 set CPU-to-DSP write block size
// - Bit 0 selects DSP-to-CPU bridge speed
// - Bits 5:4 convert DSP-to-CPU INCR reads
// - Bits 3:2 set DSP-to-CPU write block size
// - Strategy bit 0 forwards writes at once
// - Strategy bit 1 waits for whole block
package dbb_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] DBB_BOOT_VEC_OFS = 8'h18;
  localparam logic [7:0] DBB_BRG_CFG_OFS = 8'h1C;
  localparam logic [31:0] DBB_BOOT_VEC_RST = 32'h0000_0000;
  localparam logic [31:0] DBB_BRG_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] DBB_BRG_CFG_MASK = 32'hE000_0FFF;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int DBB_PAD_PULL_LSB = 30;
  localparam int DBB_CKE_LOW_BIT = 29;
  localparam int DBB_C2D_RDCNV_LSB = 10;
  localparam int DBB_C2D_BLK_LSB = 8;
  localparam int DBB_C2D_WSTRAT_BIT = 7;
  localparam int DBB_C2D_SEL_BIT = 6;
  localparam int DBB_D2C_RDCNV_LSB = 4;
  localparam int DBB_D2C_BLK_LSB = 2;
  localparam int DBB_D2C_WSTRAT_BIT = 1;
  localparam int DBB_D2C_SEL_BIT = 0;

  // ---------------------------------------------------------------
  // Field codes
  // ---------------------------------------------------------------
  localparam logic [1:0] DBB_PULL_DOWN = 2'h0;
  localparam logic [1:0] DBB_PULL_UP = 2'h3;
  localparam logic [1:0] DBB_RESP_OKAY = 2'h0;
  localparam logic [1:0] DBB_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {DBB_RD_KEEP, DBB_RD_INCR4, DBB_RD_INCR8, DBB_RD_INCR16} dbb_rdcnv_e;
  typedef enum logic [1:0] {DBB_BLK_BURST, DBB_BLK_INCR4, DBB_BLK_RSV2, DBB_BLK_RSV3} dbb_blk_e;

  // One bridge direction as seen by the bridge logic
  typedef struct packed {
    logic high_speed;
    dbb_rdcnv_e rd_conv;
    dbb_blk_e blk_size;
    logic wr_block;
  } dbb_bridge_s;

endpackage : dbb_pkg

//--- hw/dbb_regs.sv
// AXI4-Lite register bank for DSP boot vector and bridge configuration
//
// Register access over AXI4-Lite was left to the implementer.
module dbb_regs
  import dbb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] dsp_boot_vector,
  output logic host_pull_en,
  output logic host_pull_up,
  input wire logic mem_cke_in,
  output logic mem_cke_out,
  output dbb_bridge_s c2d_bridge,
  output dbb_bridge_s d2c_bridge
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [31:0] boot_q;
  logic [31:0] cfg_q;
  logic [7:0] awaddr_q;
  logic aw_have_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic w_have_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // ---------------------------------------------------------------
  // Write channel
  // ---------------------------------------------------------------
  // Address and data are latched independently, so either may come first
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire aw_ok = aw_have_q || aw_take;
  wire w_ok = w_have_q || w_take;
  wire wr_fire = aw_ok && w_ok && !bvalid_q;
  wire [7:0] wr_addr = aw_have_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_have_q ? wdata_q : s_axi_wdata;
  wire [3:0] wr_strb = w_have_q ? wstrb_q : s_axi_wstrb;
  wire wr_boot = wr_fire && (wr_addr[7:2] == DBB_BOOT_VEC_OFS[7:2]);
  wire wr_cfg = wr_fire && (wr_addr[7:2] == DBB_BRG_CFG_OFS[7:2]);

  logic [31:0] strb_mask;
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      strb_mask[i*8 +: 8] = {8{wr_strb[i]}};
    end
  end

  wire [31:0] boot_d = (boot_q & ~strb_mask) | (wr_data & strb_mask);
  // Reserved bits 28:12 are not stored and read back as zero
  wire [31:0] cfg_d = ((cfg_q & ~strb_mask) | (wr_data & strb_mask))
                      & DBB_BRG_CFG_MASK;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      boot_q <= DBB_BOOT_VEC_RST;
      cfg_q <= DBB_BRG_CFG_RST;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= DBB_RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (wr_boot || wr_cfg) ? DBB_RESP_OKAY : DBB_RESP_SLVERR;
      end
      else
      begin
        aw_have_q <= aw_ok;
        w_have_q <= w_ok;
        if (s_axi_bready)
        begin
          bvalid_q <= 1'b0;
        end
      end
      if (wr_boot)
      begin
        boot_q <= boot_d;
      end
      if (wr_cfg)
      begin
        cfg_q <= cfg_d;
      end
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  assign s_axi_arready = !rvalid_q;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire rd_boot = s_axi_araddr[7:2] == DBB_BOOT_VEC_OFS[7:2];
  wire rd_cfg = s_axi_araddr[7:2] == DBB_BRG_CFG_OFS[7:2];
  wire [31:0] rd_mux = rd_boot ? boot_q : (rd_cfg ? cfg_q : 32'h0000_0000);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= DBB_RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= (rd_boot || rd_cfg) ? DBB_RESP_OKAY : DBB_RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ---------------------------------------------------------------
  // Field decode
  // ---------------------------------------------------------------
  assign dsp_boot_vector = boot_q;

  wire [1:0] pull_code = cfg_q[DBB_PAD_PULL_LSB +: 2];
  // Reserved pull codes leave the pads unpulled rather than guessing
  assign host_pull_en = (pull_code == DBB_PULL_DOWN) || (pull_code == DBB_PULL_UP);
  assign host_pull_up = pull_code == DBB_PULL_UP;

  assign mem_cke_out = mem_cke_in && !cfg_q[DBB_CKE_LOW_BIT];

  wire c2d_hs = cfg_q[DBB_C2D_SEL_BIT];
  wire d2c_hs = cfg_q[DBB_D2C_SEL_BIT];

  // Low-speed bridge sees neutral settings: keep INCR, burst block, low latency
  always_comb
  begin
    c2d_bridge.high_speed = c2d_hs;
    c2d_bridge.rd_conv = c2d_hs ? dbb_rdcnv_e'(cfg_q[DBB_C2D_RDCNV_LSB +: 2])
                                : DBB_RD_KEEP;
    c2d_bridge.blk_size = c2d_hs ? dbb_blk_e'(cfg_q[DBB_C2D_BLK_LSB +: 2])
                                 : DBB_BLK_BURST;
    c2d_bridge.wr_block = c2d_hs && cfg_q[DBB_C2D_WSTRAT_BIT];
    d2c_bridge.high_speed = d2c_hs;
    d2c_bridge.rd_conv = d2c_hs ? dbb_rdcnv_e'(cfg_q[DBB_D2C_RDCNV_LSB +: 2])
                                : DBB_RD_KEEP;
    d2c_bridge.blk_size = d2c_hs ? dbb_blk_e'(cfg_q[DBB_D2C_BLK_LSB +: 2])
                                 : DBB_BLK_BURST;
    d2c_bridge.wr_block = d2c_hs && cfg_q[DBB_D2C_WSTRAT_BIT];
  end

endmodule : dbb_regs

//--- sim/dbb_regs_properties.sv
// Port checker for the boot vector and bridge configuration bank
module dbb_regs_properties
  import dbb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic mem_cke_in,
  input wire logic mem_cke_out,
  input wire logic host_pull_en,
  input wire logic host_pull_up,
  input wire dbb_bridge_s c2d_bridge,
  input wire dbb_bridge_s d2c_bridge
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_wr_ans; s_wr_both |=> s_axi_bvalid; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write unanswered");
  property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read unanswered");
  property p_rd_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_cke; mem_cke_out |-> mem_cke_in; endproperty
  a_cke: assert property (p_cke) else $error("cke raised without source");
  property p_pull; host_pull_up |-> host_pull_en; endproperty
  a_pull: assert property (p_pull) else $error("pull up while disabled");
  property p_c2d_off; !c2d_bridge.high_speed |-> c2d_bridge == 6'h00; endproperty
  a_c2d_off: assert property (p_c2d_off) else $error("c2d fields leak");
  property p_d2c_off; !d2c_bridge.high_speed |-> d2c_bridge == 6'h00; endproperty
  a_d2c_off: assert property (p_d2c_off) else $error("d2c fields leak");
  // Bridge and pull outputs move only when a write lands
  property p_cfg_cause;
    $changed({c2d_bridge, d2c_bridge, host_pull_en, host_pull_up}) |-> $rose(s_axi_bvalid);
  endproperty
  a_cfg_cause: assert property (p_cfg_cause) else $error("config moved alone");
endmodule : dbb_regs_properties

bind dbb_regs dbb_regs_properties i_dbb_regs_properties (.*);

//--- sim/dbb_far_model.sv
// Far-side model: memory controller cke source
module dbb_far_model
(
  input wire logic sys_clk,
  output logic mem_cke_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Toggles each cycle so a stuck cke path shows
  initial mem_cke_in = 1'b1;
  always @(posedge sys_clk) mem_cke_in <= ~mem_cke_in;
endmodule : dbb_far_model

//--- sim/dbb_regs_tb_top.sv
// Testbench for the boot vector and bridge configuration bank
module dbb_regs_tb_top;
  import dbb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, dsp_boot_vector, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, mem_cke_in, mem_cke_out;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic host_pull_en, host_pull_up;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  dbb_bridge_s c2d_bridge, d2c_bridge;
  int bad_count = 0, checks_done = 0;
  always #12.5 sys_clk = ~sys_clk;
  dbb_regs i_dbb_regs (.*);
  dbb_far_model i_dbb_far_model (.*);
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic summarize;
    if (bad_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One access; handshakes judged at the negedge before each rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tr;
    @(posedge sys_clk);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    repeat (50)
    begin
      @(negedge sys_clk);
      ta = s_axi_awvalid & s_axi_awready | s_axi_arvalid & s_axi_arready;
      tw = s_axi_wvalid & s_axi_wready;
      tr = s_axi_bvalid & s_axi_bready | s_axi_rvalid & s_axi_rready;
      resp = w ? s_axi_bresp : s_axi_rresp;
      rd = s_axi_rdata;
      @(posedge sys_clk);
      s_axi_awvalid <= s_axi_awvalid & !ta;
      s_axi_arvalid <= s_axi_arvalid & !ta;
      s_axi_wvalid <= s_axi_wvalid & !tw;
      if (tr)
      begin
        {s_axi_bready, s_axi_rready} <= 2'h0;
        return;
      end
    end
    bad_count++;
    summarize();
  endtask : xfer
  task automatic t_reset;
    chk({host_pull_en, host_pull_up, c2d_bridge, d2c_bridge}, 32'h2000);
    xfer(1'b0, DBB_BOOT_VEC_OFS, 32'h0);
    chk(rd, DBB_BOOT_VEC_RST);
    xfer(1'b0, DBB_BRG_CFG_OFS, 32'h0);
    chk({rd, resp}, {DBB_BRG_CFG_RST, DBB_RESP_OKAY});
  endtask : t_reset
  task automatic t_boot;
    xfer(1'b1, DBB_BOOT_VEC_OFS, 32'hA5A5_5A5A);
    chk(resp, DBB_RESP_OKAY);
    s_axi_wstrb <= 4'h3;
    xfer(1'b1, DBB_BOOT_VEC_OFS, 32'hFFFF_FFFF);
    s_axi_wstrb <= 4'hF;
    xfer(1'b0, DBB_BOOT_VEC_OFS, 32'h0);
    chk(rd, 32'hA5A5_FFFF);
    chk(dsp_boot_vector, 32'hA5A5_FFFF);
  endtask : t_boot
  task automatic t_cfg;
    logic [31:0] d;
    xfer(1'b1, DBB_BRG_CFG_OFS, 32'hFFFF_FFFF);
    chk(resp, DBB_RESP_OKAY);
    xfer(1'b0, DBB_BRG_CFG_OFS, 32'h0);
    chk(rd, 32'hE000_0FFF);
    chk({c2d_bridge, d2c_bridge, host_pull_up, mem_cke_out}, 32'h3FFE);
    for (int i = 0; i < 4; i++)
    begin
      d = {i[1:0], 1'b0, 17'h0, i[1:0], i[1:0], i[1], ~i[0], i[1:0], i[1:0], i[1], i[0]};
      xfer(1'b1, DBB_BRG_CFG_OFS, d);
      xfer(1'b0, DBB_BRG_CFG_OFS, 32'h0);
      chk(rd, d);
      chk({c2d_bridge, d2c_bridge}, i[0] ? {6'h00, 1'b1, i[1:0], i[1:0], i[1]}
        : {1'b1, i[1:0], i[1:0], i[1], 6'h00});
      chk({host_pull_en, host_pull_up, mem_cke_out ^ mem_cke_in}, {i == 0 || i == 3, i == 3, 1'b0});
    end
  endtask : t_cfg
  task automatic t_bad;
    xfer(1'b1, 8'h40, 32'h1234_5678);
    chk(resp, DBB_RESP_SLVERR);
    xfer(1'b0, 8'h40, 32'h0);
    chk({rd, resp}, {32'h0, DBB_RESP_SLVERR});
    chk(dsp_boot_vector, 32'hA5A5_FFFF);
  endtask : t_bad
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_boot();
    t_cfg();
    t_bad();
    summarize();
  end
endmodule : dbb_regs_tb_top
